/* hdl/pms_consts.svh */
/*
  Constants of the power-mode sequencer: register offsets, field positions,
  reset values and timing figures.
  Assumes inclusion by bare name from the sequencer file.
*/
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PMS_CLK_MHZ          100
`define PMS_WAKE_WINDOW_US   9000
`define PMS_WAKE_WINDOW_CYC  (`PMS_WAKE_WINDOW_US * `PMS_CLK_MHZ)
`define PMS_FILTER_CYC       16

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define PMS_ADDR_W           4
`define PMS_OFS_CMD          4'h0
`define PMS_OFS_CFG          4'h4
`define PMS_OFS_STATUS       4'h8

// Command register, write-one-to-act
`define PMS_CMD_CHARGE_ON    0
`define PMS_CMD_SLEEP        1
`define PMS_CMD_POWER_OFF    2

// Configuration register
`define PMS_CFG_KEEP_BOOST   0
`define PMS_CFG_SAFING_25V   1
`define PMS_CFG_W            2
`define PMS_CFG_RESET        2'h0

// Status register fields
`define PMS_ST_MODE_LSB      0
`define PMS_ST_WAKE          4
`define PMS_ST_BATT          5
`define PMS_ST_SUPPLY        6
`define PMS_ST_RST_FREE      7
`define PMS_ST_WINDOW        8
`define PMS_ST_SLEEP_PEND    9
`define PMS_ST_CHARGE        10

`endif

/* hdl/pms_pkg.sv */
/*
  Types shared by the power-mode sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pms_pkg;

  // --------------------------------------------------------------------------
  // Power modes
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    PMS_OFF,
    PMS_SLEEP,
    PMS_ACTIVE,
    PMS_RESERVE,
    PMS_SHUTDOWN
  } pms_mode_t;

endpackage

/* hdl/pms_sequencer.sv */
/*
  Power-mode sequencer: power-off, sleep, active and passive (energy reserve
  and shutdown) modes, regulator start order, host reset release, reserve
  switch and crossover output, with an Avalon-MM register slave.
  Assumes comparator and pin inputs are asynchronous to MCLK_I and that
  RESET_I stands for the internal power-on reset.
*/
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pms_consts.svh"

module pms_sequencer #(
  parameter int WINDOW_CYC = `PMS_WAKE_WINDOW_CYC,
  parameter int FILTER_CYC = `PMS_FILTER_CYC
) (
  input  wire logic        MCLK_I,
  input  wire logic        RESET_I,
  input  wire logic        WAKE_PIN_I,
  input  wire logic        BATT_MON_GOOD_I,
  input  wire logic        SUPPLY_GOOD_I,
  input  wire logic        MAIN5V_GOOD_I,
  input  wire logic        HOST3V3_GOOD_I,
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  output logic             INT_RAILS_EN_O,
  output logic             BOOST_EN_O,
  output logic             MAIN5V_EN_O,
  output logic             HOST3V3_EN_O,
  output logic             HOST_RESET_N_O,
  output logic             CHARGE_EN_O,
  output logic             RESERVE_SW_O,
  output logic             CROSSOVER_O,
  output logic             SAFING_25V_O
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  // Synchronised input count and counter widths
  localparam int NSYNC = 5;
  localparam int WIN_W = $clog2(WINDOW_CYC + 1);
  localparam int FLT_W = $clog2(FILTER_CYC + 1);

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] lvl_q;

  assign async_in = {HOST3V3_GOOD_I, MAIN5V_GOOD_I, SUPPLY_GOOD_I, BATT_MON_GOOD_I, WAKE_PIN_I};

  // Three stages; a level is accepted only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
          s1_q[gi]  <= 1'b0;
          s2_q[gi]  <= 1'b0;
          s3_q[gi]  <= 1'b0;
          lvl_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= async_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            lvl_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // Accepted comparator levels; bit order follows async_in
  wire batt_good   = lvl_q[1];
  wire supply_good = lvl_q[2];
  wire main5v_good = lvl_q[3];
  wire host3_good  = lvl_q[4];

  // --------------------------------------------------------------------------
  // Wake pin glitch filter
  // --------------------------------------------------------------------------
  logic             wake_q;
  logic [FLT_W-1:0] flt_cnt_q;
  logic [FLT_W-1:0] flt_cnt_d;
  logic             wake_d;

  // A longer filter rejects longer transients but delays every mode change driven by the wake pin
  assign wake_d    = (lvl_q[0] != wake_q) && (flt_cnt_q == FLT_W'(FILTER_CYC - 1)) ? lvl_q[0] : wake_q;
  assign flt_cnt_d = (lvl_q[0] == wake_q) || (wake_d != wake_q) ? '0 : flt_cnt_q + FLT_W'(1);

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wake_q    <= 1'b0;
      flt_cnt_q <= '0;
    end else begin
      wake_q    <= wake_d;
      flt_cnt_q <= flt_cnt_d;
    end
  end

  // --------------------------------------------------------------------------
  // Register slave decode
  // --------------------------------------------------------------------------
  logic                     wait_q;
  logic [`PMS_CFG_W-1:0]    cfg_q;
  logic                     sleep_pend_q;
  logic                     charge_q;
  logic                     rst_free_q;
  logic                     win_done_q;
  pms_pkg::pms_mode_t       mode_q;
  pms_pkg::pms_mode_t       mode_d;

  // Request qualifiers and address hits
  wire        req      = AVS_READ_I | AVS_WRITE_I;
  wire        accept   = req & ~wait_q;
  wire        wr_lane0 = AVS_WRITE_I & accept & AVS_BYTEENABLE_I[0];
  wire        hit_cmd  = AVS_ADDRESS_I == `PMS_OFS_CMD;
  wire        hit_cfg  = AVS_ADDRESS_I == `PMS_OFS_CFG;
  wire        hit_st   = AVS_ADDRESS_I == `PMS_OFS_STATUS;
  wire        wr_cmd   = wr_lane0 & hit_cmd;
  wire        cmd_chg  = wr_cmd & AVS_WRITEDATA_I[`PMS_CMD_CHARGE_ON];
  wire        cmd_slp  = wr_cmd & AVS_WRITEDATA_I[`PMS_CMD_SLEEP];
  wire        cmd_off  = wr_cmd & AVS_WRITEDATA_I[`PMS_CMD_POWER_OFF];
  wire [31:0] status;
  wire [31:0] rd_mux;

  assign status = {21'h0, charge_q, sleep_pend_q, win_done_q, rst_free_q,
                   supply_good, batt_good, wake_q, 4'(mode_q)};
  // Unmapped and command addresses read as zero
  assign rd_mux = hit_st  ? status :
                  hit_cfg ? {30'h0, cfg_q} : 32'h0;

  // One wait cycle: waitrequest drops for exactly one cycle per request
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // Configuration: keep-boost and safing level, both clear after reset
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cfg_q <= `PMS_CFG_RESET;
    end else if (wr_lane0 & hit_cfg) begin
      cfg_q <= AVS_WRITEDATA_I[`PMS_CFG_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Host commands
  // --------------------------------------------------------------------------
  wire in_active = mode_q == pms_pkg::PMS_ACTIVE;
  // Sleep taken only with wake low; pending until active is left or wake rises, set beats clear
  wire slp_set   = cmd_slp & ~wake_q & in_active & win_done_q;
  wire slp_clr   = ~in_active | wake_q;

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sleep_pend_q <= 1'b0;
    end else if (slp_set) begin
      sleep_pend_q <= 1'b1;
    end else if (slp_clr) begin
      sleep_pend_q <= 1'b0;
    end
  end

  // Charge source: only after the host left reset, dropped outside active
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      charge_q <= 1'b0;
    end else if (cmd_chg & rst_free_q & in_active) begin
      charge_q <= 1'b1;
    end else if (~in_active) begin
      charge_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Active-entry window
  // --------------------------------------------------------------------------
  // Counts from active entry and restarts on every new entry
  logic [WIN_W-1:0] win_cnt_q;
  wire              win_last = win_cnt_q == WIN_W'(WINDOW_CYC - 1);

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      win_cnt_q  <= '0;
      win_done_q <= 1'b0;
    end else if (~in_active) begin
      win_cnt_q  <= '0;
      win_done_q <= 1'b0;
    end else if (~win_done_q) begin
      win_cnt_q  <= win_cnt_q + WIN_W'(1);
      win_done_q <= win_last;
    end
  end

  // --------------------------------------------------------------------------
  // Mode machine
  // --------------------------------------------------------------------------
  // Supply comparator alone selects reserve; the battery monitor only wakes
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      pms_pkg::PMS_OFF: begin
        if (wake_q) begin
          mode_d = pms_pkg::PMS_SLEEP;
        end
      end
      pms_pkg::PMS_SLEEP: begin
        if (~wake_q) begin
          mode_d = pms_pkg::PMS_OFF;
        end else if (batt_good) begin
          mode_d = pms_pkg::PMS_ACTIVE;
        end
      end
      pms_pkg::PMS_ACTIVE: begin
        if (~supply_good) begin
          mode_d = pms_pkg::PMS_RESERVE;
        end else if (~wake_q & ~win_done_q) begin
          mode_d = pms_pkg::PMS_SLEEP;
        end else if (~wake_q & sleep_pend_q) begin
          mode_d = pms_pkg::PMS_SHUTDOWN;
        end
      end
      pms_pkg::PMS_RESERVE: begin
        mode_d = pms_pkg::PMS_RESERVE;
      end
      pms_pkg::PMS_SHUTDOWN: begin
        if (cmd_off) begin
          mode_d = pms_pkg::PMS_OFF;
        end
      end
      default: begin
        mode_d = pms_pkg::PMS_OFF;
      end
    endcase
  end

  // Power-on reset lands in power-off; it is the only way out of reserve
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mode_q <= pms_pkg::PMS_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  // --------------------------------------------------------------------------
  // Supply enables and start order
  // --------------------------------------------------------------------------
  // Reserve and shutdown share the passive outputs; decoded for mode_q and mode_d
  function automatic logic is_passive(input pms_pkg::pms_mode_t m);
    return (m == pms_pkg::PMS_RESERVE) || (m == pms_pkg::PMS_SHUTDOWN);
  endfunction

  wire passive  = is_passive(mode_q);
  wire powered  = in_active | passive;
  wire rails_d  = mode_q != pms_pkg::PMS_OFF;
  wire boost_d  = in_active | (passive & cfg_q[`PMS_CFG_KEEP_BOOST]);
  // Host rail follows main 5 V good; a stale good with main off is ignored
  wire host3_d  = powered & MAIN5V_EN_O & main5v_good;
  // Reset release is sticky within a powered period so rail ripple in
  // passive mode does not kick the host
  wire rfree_d  = powered & (rst_free_q | (HOST3V3_EN_O & host3_good));
  // Switch, crossover and charge follow the next mode so they act on the entry edge
  wire switch_d = is_passive(mode_d);
  wire charge_d = charge_q & in_active & (mode_d == pms_pkg::PMS_ACTIVE);

  // Enables are registered; rails, boost and main trail the mode by one cycle
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      INT_RAILS_EN_O <= 1'b0;
      BOOST_EN_O     <= 1'b0;
      MAIN5V_EN_O    <= 1'b0;
      HOST3V3_EN_O   <= 1'b0;
      rst_free_q     <= 1'b0;
    end else begin
      INT_RAILS_EN_O <= rails_d;
      BOOST_EN_O     <= boost_d;
      MAIN5V_EN_O    <= powered;
      HOST3V3_EN_O   <= host3_d;
      rst_free_q     <= rfree_d;
    end
  end

  // --------------------------------------------------------------------------
  // Pin outputs
  // --------------------------------------------------------------------------
  // Every pin registered so no decode glitch reaches a regulator or the host
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      HOST_RESET_N_O <= 1'b0;
      CHARGE_EN_O    <= 1'b0;
      RESERVE_SW_O   <= 1'b0;
      CROSSOVER_O    <= 1'b0;
      SAFING_25V_O   <= 1'b0;
      AVS_READDATA_O <= 32'h0;
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      HOST_RESET_N_O <= rfree_d;
      CHARGE_EN_O    <= charge_d;
      RESERVE_SW_O   <= switch_d;
      CROSSOVER_O    <= switch_d;
      SAFING_25V_O   <= cfg_q[`PMS_CFG_SAFING_25V];
      AVS_READDATA_O <= rd_mux;
      AVS_WAITREQUEST_O <= ~(req & wait_q);
    end
  end

endmodule

/* tb/pms_sequencer_assertions.sv */
/*
  Port checker for the power-mode sequencer.
  Assumes it is bound onto pms_sequencer and sees only its ports.
*/
`timescale 1ns/1ps
module pms_sequencer_chk (
  input wire logic       MCLK_I,
  input wire logic       RESET_I,
  input wire logic       WAKE_PIN_I,
  input wire logic       SUPPLY_GOOD_I,
  input wire logic       MAIN5V_GOOD_I,
  input wire logic       HOST3V3_GOOD_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic       AVS_WRITE_I,
  input wire logic       INT_RAILS_EN_O,
  input wire logic       BOOST_EN_O,
  input wire logic       MAIN5V_EN_O,
  input wire logic       HOST3V3_EN_O,
  input wire logic       HOST_RESET_N_O,
  input wire logic       CHARGE_EN_O,
  input wire logic       RESERVE_SW_O,
  input wire logic       CROSSOVER_O,
  input wire logic       SAFING_25V_O
);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  // Supply lost while running, held low long enough to clear the synchroniser
  sequence supply_lost_s;
    $fell(SUPPLY_GOOD_I) && MAIN5V_EN_O ##1 !SUPPLY_GOOD_I [*8];
  endsequence
  sequence rails_up_s;
    $rose(INT_RAILS_EN_O);
  endsequence
  off_quiet_a: assert property (!INT_RAILS_EN_O |-> !(BOOST_EN_O || MAIN5V_EN_O || CHARGE_EN_O || RESERVE_SW_O))
    else $error("Supply enabled while internal rails are off");
  wake_start_a: assert property (rails_up_s |-> $past(WAKE_PIN_I, 2))
    else $error("Internal rails rose without a wake level");
  boost_pair_a: assert property ($rose(MAIN5V_EN_O) |-> $rose(BOOST_EN_O))
    else $error("Boost and main rail not enabled together");
  host_order_a: assert property ($rose(HOST3V3_EN_O) |-> MAIN5V_EN_O && $past(MAIN5V_GOOD_I, 2))
    else $error("Host rail enabled before main rail good");
  reset_order_a: assert property ($rose(HOST_RESET_N_O) |-> HOST3V3_EN_O && $past(HOST3V3_GOOD_I, 2))
    else $error("Host reset released before host rail good");
  charge_gate_a: assert property ($rose(CHARGE_EN_O) |-> HOST_RESET_N_O)
    else $error("Charge source on before host reset release");
  switch_pair_a: assert property (CROSSOVER_O == RESERVE_SW_O)
    else $error("Crossover output and reserve switch disagree");
  charge_cut_a: assert property ($rose(RESERVE_SW_O) |-> !CHARGE_EN_O)
    else $error("Charge source still on in passive mode");
  supply_loss_a: assert property (supply_lost_s |-> ##[0:6] RESERVE_SW_O)
    else $error("No reserve switch after supply loss");
  switch_hold_a: assert property ($fell(RESERVE_SW_O) |-> ##1 !INT_RAILS_EN_O)
    else $error("Reserve switch opened without going to power-off");
  safing_cause_a: assert property ($changed(SAFING_25V_O) |-> $past(AVS_WRITE_I, 2) && $past(AVS_ADDRESS_I, 2) == 4'h4)
    else $error("Safing level changed without a register write");
endmodule

bind pms_sequencer pms_sequencer_chk i_pms_sequencer_chk (
  .MCLK_I, .RESET_I, .WAKE_PIN_I, .SUPPLY_GOOD_I, .MAIN5V_GOOD_I, .HOST3V3_GOOD_I, .AVS_ADDRESS_I,
  .AVS_WRITE_I, .INT_RAILS_EN_O, .BOOST_EN_O, .MAIN5V_EN_O, .HOST3V3_EN_O, .HOST_RESET_N_O,
  .CHARGE_EN_O, .RESERVE_SW_O, .CROSSOVER_O, .SAFING_25V_O);

/* tb/pms_host_model.sv */
/*
  Host-side partner: register bus master tasks and the regulator good feedback.
  Assumes one clock shared with the sequencer.
*/
`timescale 1ns/1ps
module pms_host_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        main5v_en_i,
  input  wire logic        host3v3_en_i,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i,
  output logic             main5v_good_o,
  output logic             host3v3_good_o,
  output logic      [3:0]  address_o    = 4'h0,
  output logic             read_o       = 1'b0,
  output logic             write_o      = 1'b0,
  output logic      [31:0] writedata_o  = 32'h0,
  output logic      [3:0]  byteenable_o = 4'h0
);
  logic [4:0] c5_q = 5'h00;
  logic [4:0] c3_q = 5'h00;
  logic [4:0] dly;
  // --------------------------------------------------------------------------
  // Regulator ramps; slow mode stretches them so the sequencer must wait
  // --------------------------------------------------------------------------
  assign dly = slow_i ? 5'h14 : 5'h03;
  always @(posedge clk_i) begin
    c5_q <= !main5v_en_i ? 5'h00 : (c5_q == dly ? c5_q : c5_q + 5'h01);
    c3_q <= !host3v3_en_i ? 5'h00 : (c3_q == dly ? c3_q : c3_q + 5'h01);
  end
  assign main5v_good_o  = main5v_en_i && (c5_q == dly);
  assign host3v3_good_o = host3v3_en_i && (c3_q == dly);
  // One bus word; held until waitrequest is sampled low, no cycle limit of its own
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    address_o    <= a;
    write_o      <= w;
    read_o       <= !w;
    writedata_o  <= d;
    byteenable_o <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (waitrequest_i !== 1'b0);
    q = readdata_i;
    write_o <= 1'b0;
    read_o  <= 1'b0;
  endtask
endmodule

/* tb/pms_sequencer_tb_top.sv */
/*
  Self-checking bench for the power-mode sequencer.
  Assumes the host partner model and the bound checker.
*/
`timescale 1ns/1ps
module pms_sequencer_tb_top;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        wake = 1'b0;
  logic        batt = 1'b0;
  logic        sup  = 1'b1;
  logic        slow = 1'b0;
  logic        m5g, h3g, rd, wr, wq, ie, bo, m5, h3, hrn, ch, sw, xo, s25;
  logic [3:0]  adr, be;
  logic [31:0] wd, rdat, q;
  int          seed, checks, error_cnt;
  pms_sequencer #(.WINDOW_CYC(200), .FILTER_CYC(4)) i_pms_sequencer (
    .MCLK_I(clk), .RESET_I(rst), .WAKE_PIN_I(wake), .BATT_MON_GOOD_I(batt), .SUPPLY_GOOD_I(sup),
    .MAIN5V_GOOD_I(m5g), .HOST3V3_GOOD_I(h3g), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
    .INT_RAILS_EN_O(ie), .BOOST_EN_O(bo), .MAIN5V_EN_O(m5), .HOST3V3_EN_O(h3), .HOST_RESET_N_O(hrn),
    .CHARGE_EN_O(ch), .RESERVE_SW_O(sw), .CROSSOVER_O(xo), .SAFING_25V_O(s25));
  pms_host_model i_host (
    .clk_i(clk), .slow_i(slow), .main5v_en_i(m5), .host3v3_en_i(h3), .readdata_i(rdat), .waitrequest_i(wq),
    .main5v_good_o(m5g), .host3v3_good_o(h3g), .address_o(adr), .read_o(rd), .write_o(wr),
    .writedata_o(wd), .byteenable_o(be));
  always #5 clk = ~clk;
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected {rails, boost, main, switch, crossover} for a mode
  function automatic logic [4:0] outs(input pms_pkg::pms_mode_t m, input logic keep);
    case (m)
      pms_pkg::PMS_SLEEP:    return 5'h10;
      pms_pkg::PMS_ACTIVE:   return 5'h1C;
      pms_pkg::PMS_RESERVE:  return {1'b1, keep, 3'h7};
      pms_pkg::PMS_SHUTDOWN: return {1'b1, keep, 3'h7};
      default:               return 5'h00;
    endcase
  endfunction
  // Polls status until the mode shows, then compares mode and outputs
  task automatic mode(input pms_pkg::pms_mode_t m, input logic keep);
    for (int i = 0; i < 40; i++) begin
      i_host.xfer(1'b0, 4'h8, 32'h0, q);
      if (q[3:0] === m) break;
    end
    repeat (2) @(posedge clk);
    chk({28'h0, q[3:0]}, {28'h0, m});
    chk({27'h0, ie, bo, m5, sw, xo}, {27'h0, outs(m, keep)});
  endtask
  task automatic up(input logic s);
    slow <= s;
    batt <= 1'b0;
    wake <= 1'b1;
    mode(pms_pkg::PMS_SLEEP, 1'b0);
    batt <= 1'b1;
    mode(pms_pkg::PMS_ACTIVE, 1'b0);
    for (int i = 0; i < 100 && !(h3 === 1'b1 && hrn === 1'b1); i++) @(posedge clk);
    chk({29'h0, h3, hrn, ch}, 32'h6);
  endtask
  task automatic results;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (checks > 0 && error_cnt == 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial begin
    seed = 32'h412AC6D5;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    mode(pms_pkg::PMS_OFF, 1'b0);
    chk({28'h0, h3, hrn, ch, s25}, 32'h0);
    i_host.xfer(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h0);
    i_host.xfer(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0);
    // Short wake pulses must be swallowed by the filter
    wake <= 1'b1;
    repeat (1 + $unsigned($random(seed)) % 3) @(posedge clk);
    wake <= 1'b0;
    repeat (30) @(posedge clk);
    mode(pms_pkg::PMS_OFF, 1'b0);
    up(1'b0);
    // Early wake loss falls back through sleep, never into passive
    wake <= 1'b0;
    batt <= 1'b0;
    mode(pms_pkg::PMS_OFF, 1'b0);
    up(1'b1);
    i_host.xfer(1'b1, 4'h0, 32'h1, q);
    repeat (3) @(posedge clk);
    chk({31'h0, ch}, 32'h1);
    repeat (260 + $unsigned($random(seed)) % 20) @(posedge clk);
    i_host.xfer(1'b1, 4'h0, 32'h2, q);
    wake <= 1'b0;
    repeat (40) @(posedge clk);
    mode(pms_pkg::PMS_ACTIVE, 1'b0);
    i_host.xfer(1'b1, 4'h0, 32'h2, q);
    mode(pms_pkg::PMS_SHUTDOWN, 1'b0);
    chk({31'h0, ch}, 32'h0);
    repeat (30) @(posedge clk);
    mode(pms_pkg::PMS_SHUTDOWN, 1'b0);
    i_host.xfer(1'b1, 4'h0, 32'h4, q);
    mode(pms_pkg::PMS_OFF, 1'b0);
    // Keep boost on and select the higher safing level
    i_host.xfer(1'b1, 4'h4, $random(seed) | 32'h3, q);
    i_host.xfer(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h3);
    chk({31'h0, s25}, 32'h1);
    up(1'b0);
    i_host.xfer(1'b1, 4'h0, 32'h1, q);
    batt <= 1'b0;
    repeat (40) @(posedge clk);
    mode(pms_pkg::PMS_ACTIVE, 1'b1);
    sup <= 1'b0;
    mode(pms_pkg::PMS_RESERVE, 1'b1);
    chk({31'h0, ch}, 32'h0);
    sup <= 1'b1;
    wake <= 1'b0;
    repeat (40) @(posedge clk);
    mode(pms_pkg::PMS_RESERVE, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    mode(pms_pkg::PMS_OFF, 1'b0);
    chk({31'h0, s25}, 32'h0);
    results;
  end
  // Cuts a hang well beyond the several hundred cycles the scenarios need
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    results;
  end
endmodule
